// File: verilog/aosd_pkg.sv
package aosd_pkg;
    // Operation
    // - power-down request, pin or register, floats outputs
    // - power-down pin low restores normal operation
    // - serial port offers power-down and standby
    // - pin mode: format pin selects binary/twos
    // - serial mode: offset, twos or gray format
    // - disable pin low drives, high floats data and fast-detect outputs
    // - bit 4 floats that channel's outputs
    // - bit 5 interleaves A rising, B falling
    // - latency depends on features; rising-edge updates
    // - capture clock driven with every output word
    // - code mapping at full scale and zero
    // - overrange flag sets and clamps code
    // - every stage switchable except half-band
    // - five recommended downconverter modes supported
    // - both channels share one tuner
    // - 32-bit complex tuner mixes toward dc
    // - tuner amplitude, phase dither and offset
    // - tuner control bit 0 clear bypasses
    // - four bytes form frequency word
    // - half-band bit 1 selects high-pass

    localparam logic [8:0] REG_CHAN_SEL = 9'h005;
    localparam logic [8:0] REG_POWER = 9'h008;
    localparam logic [8:0] REG_OUT_MODE = 9'h014;
    localparam logic [8:0] REG_STATUS = 9'h0FE;
    localparam logic [8:0] REG_HB_CTRL = 9'h103;
    localparam logic [8:0] REG_STAGE_EN = 9'h104;
    localparam logic [8:0] REG_TUNER_CTRL = 9'h11D;
    localparam logic [8:0] REG_FREQ0 = 9'h11E;
    localparam logic [8:0] REG_FREQ1 = 9'h11F;
    localparam logic [8:0] REG_FREQ2 = 9'h120;
    localparam logic [8:0] REG_FREQ3 = 9'h121;
    localparam logic [8:0] REG_PHASE0 = 9'h122;
    localparam logic [8:0] REG_PHASE1 = 9'h123;

    localparam int OM_FORMAT_LSB = 0;
    localparam int OM_DISABLE_BIT = 4;
    localparam int OM_INTERLEAVE_BIT = 5;
    localparam int HB_HIGHPASS_BIT = 1;
    localparam int HB_DECIM_PHASE_BIT = 3;
    localparam int SE_FIR_BIT = 0;
    localparam int SE_FS8_BIT = 1;
    localparam int TC_ENABLE_BIT = 0;
    localparam int TC_AMP_DITHER_BIT = 1;
    localparam int TC_PHASE_DITHER_BIT = 2;

    localparam logic [1:0] CHAN_SEL_RESET = 2'h3;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;

    localparam logic signed [15:0] IN_HI_LIMIT = 16'sh3FFF;
    localparam logic signed [15:0] IN_LO_LIMIT = 16'shBFFF;
    localparam logic signed [16:0] ROUND_MAX = 17'sh01FFF;
    localparam logic [13:0] CODE_POS = 14'h1FFF;
    localparam logic [13:0] CODE_NEG = 14'h2000;

    typedef enum logic [1:0] {
        FMT_OFFSET = 2'b00,
        FMT_TWOS = 2'b01,
        FMT_GRAY = 2'b10
    } format_type;

    typedef enum logic [1:0] {
        PWR_ON = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_STANDBY = 2'b10
    } power_type;

    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_FIRST = 3'b001,
        LK_RISE = 3'b010,
        LK_SECOND = 3'b011,
        LK_FALL = 3'b100
    } link_state_type;

    typedef struct packed {
        logic tunerOn;
        logic ampDither;
        logic ditherBit;
        logic highPass;
        logic firOn;
        logic fs8On;
        logic decimSlot;
        logic [1:0] quadrant;
        logic [2:0] fs8Step;
    } chan_ctrl_type;

    typedef struct packed {
        logic [13:0] dataA;
        logic [13:0] dataB;
        logic ovrA;
        logic ovrB;
    } out_word_type;
endpackage : aosd_pkg

// File: verilog/aosd_output_stage.sv
`timescale 1ns/10ps

module aosd_channel (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic halt,
    input aosd_pkg::chan_ctrl_type ctrl,
    // converter sample, half-LSB units
    input wire logic signed [15:0] sampleIn,
    // result, twos complement
    output logic [13:0] code,
    output logic overrange,
    output logic wordValid
);
    logic signed [13:0] codeS;
    logic signed [14:0] x, mixI, mixQ, mI, mQ, pI, pQ, hbI, hbQ, d1I, d1Q, d2I, d2Q, fI, fQ;
    logic signed [15:0] sumI, sumQ, rotated;
    logic signed [16:0] rounded, firI, firQ;
    logic [13:0] clamped, fs8Code;
    logic overHi, overLo, ovrS, ovrPair, ovrOut, complexOut;

    function automatic logic signed [14:0] scale(input logic signed [14:0] v,
                                                 input logic [2:0] n);
        logic signed [14:0] r;
        r = (v >>> 1) + (v >>> 3) + (v >>> 4) + (v >>> 6);
        case (n)
            3'h0: scale = v;
            3'h1: scale = r;
            3'h2: scale = '0;
            3'h3: scale = -r;
            3'h4: scale = -v;
            3'h5: scale = -r;
            3'h6: scale = '0;
            default: scale = r;
        endcase
    endfunction : scale

    function automatic logic [13:0] sat14(input logic signed [15:0] v);
        if (v > $signed({2'b00, aosd_pkg::CODE_POS}))
            sat14 = aosd_pkg::CODE_POS;
        else if (v < $signed({2'b11, aosd_pkg::CODE_NEG}))
            sat14 = aosd_pkg::CODE_NEG;
        else
            sat14 = v[13:0];
    endfunction : sat14

    // beyond full scale by more than half an LSB flags and clamps
    assign rounded = ($signed({sampleIn[15], sampleIn}) + 17'sh00001) >>> 1;
    assign overHi = sampleIn > aosd_pkg::IN_HI_LIMIT;
    assign overLo = sampleIn < aosd_pkg::IN_LO_LIMIT;
    assign clamped = overHi ? aosd_pkg::CODE_POS :
                     overLo ? aosd_pkg::CODE_NEG :
                     (rounded > aosd_pkg::ROUND_MAX) ? aosd_pkg::CODE_POS :
                     rounded[13:0];

    // amplitude dither nudges the lsb to break up quantisation spurs
    assign x = {codeS[13], codeS} + {14'h0000, ctrl.ampDither & ctrl.ditherBit};

    // coarse quadrant mixer; a fine angle table would cost far more area
    always_comb
    begin
        mixI = x;
        mixQ = '0;
        if (ctrl.tunerOn)
        begin
            case (ctrl.quadrant)
                2'h0: begin mixI = x; mixQ = '0; end
                2'h1: begin mixI = '0; mixQ = -x; end
                2'h2: begin mixI = -x; mixQ = '0; end
                default: begin mixI = '0; mixQ = x; end
            endcase
        end
    end

    // half-band is always in the path, only its response switches
    assign sumI = ctrl.highPass ? (mI - pI) : (mI + pI);
    assign sumQ = ctrl.highPass ? (mQ - pQ) : (mQ + pQ);
    assign hbI = sumI[15:1];
    assign hbQ = sumQ[15:1];
    assign firI = hbI + (d1I <<< 1) + d2I;
    assign firQ = hbQ + (d1Q <<< 1) + d2Q;
    assign rotated = scale(fI, ctrl.fs8Step) - scale(fQ, ctrl.fs8Step - 3'h2);
    assign complexOut = ctrl.tunerOn & ~ctrl.fs8On;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            {codeS, ovrS, mI, mQ, pI, pQ} <= '0;
        end
        else if (halt)
        begin
            {codeS, ovrS, mI, mQ, pI, pQ} <= '0;
        end
        else
        begin
            codeS <= clamped;
            ovrS <= overHi | overLo;
            mI <= mixI;
            mQ <= mixQ;
            pI <= mI;
            pQ <= mQ;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            {d1I, d1Q, d2I, d2Q, fI, fQ, fs8Code, ovrPair, ovrOut} <= '0;
        end
        else if (halt)
        begin
            {d1I, d1Q, d2I, d2Q, fI, fQ, fs8Code, ovrPair, ovrOut} <= '0;
        end
        else
        begin
            ovrPair <= ctrl.decimSlot ? ovrS : (ovrPair | ovrS);
            if (ctrl.decimSlot)
            begin
                d1I <= hbI;
                d1Q <= hbQ;
                d2I <= d1I;
                d2Q <= d1Q;
                fI <= ctrl.firOn ? firI[16:2] : hbI;
                fQ <= ctrl.firOn ? firQ[16:2] : hbQ;
                ovrOut <= ovrPair | ovrS;
            end
            // the translator adds a register, so latency grows in mode 5
            fs8Code <= sat14(rotated);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            code <= '0;
            overrange <= 1'b0;
            wordValid <= 1'b0;
        end
        else
        begin
            // complex: I in the decimation slot, Q in the other
            code <= ctrl.fs8On ? fs8Code :
                    (complexOut & ~ctrl.decimSlot) ? sat14({fQ[14], fQ}) :
                    sat14({fI[14], fI});
            overrange <= ovrOut;
            wordValid <= ~halt & (complexOut | ctrl.decimSlot);
        end
    end
endmodule : aosd_channel

module aosd_output_stage (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic clk_link,
    input wire logic rst,
    // converter samples, half-LSB units
    input wire logic signed [15:0] sampleA,
    input wire logic signed [15:0] sampleB,
    // control pins
    input wire logic powerDownRequest,
    input wire logic serialClockFormatSelect,
    input wire logic monitorOutOutputDisable,
    input wire logic serialMode,
    // register port
    input wire logic regWrite,
    input wire logic [8:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // power status
    output logic referencePowered,
    output logic corePowered,
    // output pins
    output logic [13:0] portAData,
    output logic portAOe,
    output logic [13:0] portBData,
    output logic portBOe,
    output logic fastDetectBitsA,
    output logic fastDetectBitsAOe,
    output logic fastDetectBitsB,
    output logic fastDetectBitsBOe,
    output logic dataCaptureClock,
    output logic dataCaptureClockOe
);
    logic [3:0] pinS1, pinS2, levels, lvS1, lvS2;
    logic [1:0] chanSel, powerMode;
    logic [7:0] outModeA, outModeB, hbCtrl, stageEn, tunerCtrl, rdMux;
    logic [31:0] tunerFreq, phaseAcc, phase;
    logic [15:0] phaseOffset, lfsr;
    logic [2:0] fs8Step, modeNum;
    logic [13:0] codeA, codeB;
    logic slot, pinSerial, pinFormat, pinDisable, pinPd, pdActive, halt;
    logic ovrA, ovrB, validA, validB, sysToggle, tgS1, tgS2, tgS3;
    aosd_pkg::format_type formatSel;
    aosd_pkg::chan_ctrl_type ctrl;
    aosd_pkg::out_word_type heldWord;
    aosd_pkg::link_state_type linkState, next_linkState;

    function automatic logic [13:0] fmt(input logic [13:0] twos,
                                        input aosd_pkg::format_type f);
        logic [13:0] ob;
        ob = {~twos[13], twos[12:0]};
        case (f)
            aosd_pkg::FMT_TWOS: fmt = twos;
            aosd_pkg::FMT_GRAY: fmt = ob ^ (ob >> 1);
            default: fmt = ob;
        endcase
    endfunction : fmt

    assign {pinSerial, pinFormat, pinDisable, pinPd} = pinS2;
    assign pdActive = pinPd | (pinSerial & (powerMode == aosd_pkg::PWR_DOWN));
    assign halt = pdActive | (pinSerial & (powerMode == aosd_pkg::PWR_STANDBY));
    assign formatSel = pinSerial ?
        aosd_pkg::format_type'(outModeA[aosd_pkg::OM_FORMAT_LSB +: 2]) :
        (pinFormat ? aosd_pkg::FMT_TWOS : aosd_pkg::FMT_OFFSET);
    assign phase = phaseAcc + {phaseOffset, 16'h0000} +
        {28'h0000000, lfsr[3:0] & {4{tunerCtrl[aosd_pkg::TC_PHASE_DITHER_BIT]}}};
    assign modeNum = !tunerCtrl[0] ? (stageEn[0] ? 3'h2 : 3'h1) :
                     !stageEn[0] ? 3'h3 : (stageEn[1] ? 3'h5 : 3'h4);
    assign ctrl = '{tunerOn: tunerCtrl[aosd_pkg::TC_ENABLE_BIT],
                    ampDither: tunerCtrl[aosd_pkg::TC_AMP_DITHER_BIT],
                    ditherBit: lfsr[15],
                    highPass: hbCtrl[aosd_pkg::HB_HIGHPASS_BIT],
                    firOn: stageEn[aosd_pkg::SE_FIR_BIT],
                    fs8On: stageEn[aosd_pkg::SE_FS8_BIT],
                    decimSlot: slot == hbCtrl[aosd_pkg::HB_DECIM_PHASE_BIT],
                    quadrant: phase[31:30],
                    fs8Step: fs8Step};
    // pin or register alone is enough to float a channel
    assign levels = {outModeA[aosd_pkg::OM_INTERLEAVE_BIT],
                     pinDisable | outModeA[aosd_pkg::OM_DISABLE_BIT],
                     pinDisable | outModeB[aosd_pkg::OM_DISABLE_BIT],
                     pdActive};

    always_comb
    begin
        case (regAddr)
            aosd_pkg::REG_CHAN_SEL: rdMux = {6'h00, chanSel};
            aosd_pkg::REG_POWER: rdMux = {6'h00, powerMode};
            aosd_pkg::REG_OUT_MODE: rdMux = chanSel[0] ? outModeA : outModeB;
            aosd_pkg::REG_STATUS: rdMux = {3'h0, modeNum, ~halt, ~pdActive};
            aosd_pkg::REG_HB_CTRL: rdMux = hbCtrl;
            aosd_pkg::REG_STAGE_EN: rdMux = stageEn;
            aosd_pkg::REG_TUNER_CTRL: rdMux = tunerCtrl;
            aosd_pkg::REG_FREQ0: rdMux = tunerFreq[7:0];
            aosd_pkg::REG_FREQ1: rdMux = tunerFreq[15:8];
            aosd_pkg::REG_FREQ2: rdMux = tunerFreq[23:16];
            aosd_pkg::REG_FREQ3: rdMux = tunerFreq[31:24];
            aosd_pkg::REG_PHASE0: rdMux = phaseOffset[7:0];
            aosd_pkg::REG_PHASE1: rdMux = phaseOffset[15:8];
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            {pinS1, pinS2} <= '0;
            chanSel <= aosd_pkg::CHAN_SEL_RESET;
            powerMode <= aosd_pkg::PWR_ON;
            {outModeA, outModeB, hbCtrl, stageEn, tunerCtrl} <= '0;
            {tunerFreq, phaseOffset, regRdata, referencePowered, corePowered} <= '0;
        end
        else
        begin
            pinS1 <= {serialMode, serialClockFormatSelect,
                      monitorOutOutputDisable, powerDownRequest};
            pinS2 <= pinS1;
            regRdata <= rdMux;
            referencePowered <= ~pdActive;
            corePowered <= ~halt;
            if (regWrite)
            begin
                case (regAddr)
                    aosd_pkg::REG_CHAN_SEL: chanSel <= regWdata[1:0];
                    aosd_pkg::REG_POWER: powerMode <= regWdata[1:0];
                    aosd_pkg::REG_OUT_MODE:
                    begin
                        if (chanSel[0]) outModeA <= regWdata;
                        if (chanSel[1]) outModeB <= regWdata;
                    end
                    aosd_pkg::REG_HB_CTRL: hbCtrl <= regWdata;
                    aosd_pkg::REG_STAGE_EN: stageEn <= regWdata;
                    aosd_pkg::REG_TUNER_CTRL: tunerCtrl <= regWdata;
                    aosd_pkg::REG_FREQ0: tunerFreq[7:0] <= regWdata;
                    aosd_pkg::REG_FREQ1: tunerFreq[15:8] <= regWdata;
                    aosd_pkg::REG_FREQ2: tunerFreq[23:16] <= regWdata;
                    aosd_pkg::REG_FREQ3: tunerFreq[31:24] <= regWdata;
                    aosd_pkg::REG_PHASE0: phaseOffset[7:0] <= regWdata;
                    aosd_pkg::REG_PHASE1: phaseOffset[15:8] <= regWdata;
                    default: ;
                endcase
            end
        end
    end

    // one accumulator serves both channels
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            phaseAcc <= '0;
            lfsr <= aosd_pkg::LFSR_SEED;
            slot <= 1'b0;
            fs8Step <= '0;
        end
        else if (halt)
        begin
            phaseAcc <= '0;
            slot <= 1'b0;
            fs8Step <= '0;
        end
        else
        begin
            phaseAcc <= phaseAcc + tunerFreq;
            lfsr <= (lfsr >> 1) ^ (lfsr[0] ? aosd_pkg::LFSR_TAPS : 16'h0000);
            slot <= ~slot;
            if (ctrl.decimSlot)
                fs8Step <= fs8Step + 3'h1;
        end
    end

    aosd_channel chanA (
        .clk_sys(clk_sys),
        .rst(rst),
        .halt(halt),
        .ctrl(ctrl),
        .sampleIn(sampleA),
        .code(codeA),
        .overrange(ovrA),
        .wordValid(validA)
    );

    aosd_channel chanB (
        .clk_sys(clk_sys),
        .rst(rst),
        .halt(halt),
        .ctrl(ctrl),
        .sampleIn(sampleB),
        .code(codeB),
        .overrange(ovrB),
        .wordValid(validB)
    );

    // held word is stable for a full sample period after each toggle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            heldWord <= '0;
            sysToggle <= 1'b0;
        end
        else if (validA & validB)
        begin
            heldWord <= '{dataA: fmt(codeA, formatSel), dataB: fmt(codeB, formatSel),
                          ovrA: ovrA, ovrB: ovrB};
            sysToggle <= ~sysToggle;
        end
    end

    always_comb
    begin
        next_linkState = linkState;
        case (linkState)
            aosd_pkg::LK_IDLE: if (tgS3 != tgS2) next_linkState = aosd_pkg::LK_FIRST;
            aosd_pkg::LK_FIRST: next_linkState = aosd_pkg::LK_RISE;
            aosd_pkg::LK_RISE: next_linkState = aosd_pkg::LK_SECOND;
            aosd_pkg::LK_SECOND: next_linkState = aosd_pkg::LK_FALL;
            aosd_pkg::LK_FALL: next_linkState = aosd_pkg::LK_IDLE;
            default: next_linkState = aosd_pkg::LK_IDLE;
        endcase
    end

    always_ff @(posedge clk_link or posedge rst)
    begin
        if (rst)
        begin
            {tgS1, tgS2, tgS3, lvS1, lvS2} <= '0;
            linkState <= aosd_pkg::LK_IDLE;
            {portAData, portBData, portAOe, portBOe, dataCaptureClock, dataCaptureClockOe} <= '0;
            {fastDetectBitsA, fastDetectBitsB, fastDetectBitsAOe, fastDetectBitsBOe} <= '0;
        end
        else
        begin
            {tgS1, tgS2, tgS3} <= {sysToggle, tgS1, tgS2};
            lvS1 <= levels;
            lvS2 <= lvS1;
            linkState <= next_linkState;
            dataCaptureClockOe <= ~lvS2[0];
            fastDetectBitsBOe <= ~lvS2[0] & ~lvS2[1] & ~lvS2[3];
            portBOe <= ~lvS2[0] & ~lvS2[1] & ~lvS2[3];
            if (linkState == aosd_pkg::LK_FIRST)
            begin
                portAData <= heldWord.dataA;
                portBData <= heldWord.dataB;
                fastDetectBitsA <= heldWord.ovrA;
                fastDetectBitsB <= heldWord.ovrB;
                portAOe <= ~lvS2[0] & ~lvS2[2];
                fastDetectBitsAOe <= ~lvS2[0] & ~lvS2[2];
            end
            if (linkState == aosd_pkg::LK_SECOND && lvS2[3])
            begin
                portAData <= heldWord.dataB;
                fastDetectBitsA <= heldWord.ovrB;
                portAOe <= ~lvS2[0] & ~lvS2[1];
                fastDetectBitsAOe <= ~lvS2[0] & ~lvS2[1];
            end
            if (linkState == aosd_pkg::LK_RISE)
                dataCaptureClock <= 1'b1;
            if (linkState == aosd_pkg::LK_FALL)
                dataCaptureClock <= 1'b0;
            if (lvS2[0])
            begin
                portAOe <= 1'b0;
                fastDetectBitsAOe <= 1'b0;
            end
        end
    end
endmodule : aosd_output_stage

// File: dv/aosd_output_stage_props.sv
`timescale 1ns/10ps

module aosd_output_stage_props (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic clk_link,
    input wire logic rst,
    // control pins
    input wire logic powerDownRequest,
    input wire logic monitorOutOutputDisable,
    input wire logic serialMode,
    // status and output pins
    input wire logic referencePowered,
    input wire logic corePowered,
    input wire logic [13:0] portAData,
    input wire logic [13:0] portBData,
    input wire logic portAOe,
    input wire logic portBOe,
    input wire logic fastDetectBitsAOe,
    input wire logic dataCaptureClock,
    input wire logic dataCaptureClockOe
);
    // pins pass two synchronisers, hence wide windows
    a_pd_floats: assert property (@(posedge clk_link) disable iff (rst)
        $rose(powerDownRequest) |-> ##[1:300] !portAOe && !portBOe && !dataCaptureClockOe)
        else $error("power-down pin left outputs driven");
    a_pd_wake: assert property (@(posedge clk_link) disable iff (rst)
        $fell(powerDownRequest) && !serialMode |-> ##[1:300] dataCaptureClockOe)
        else $error("capture clock not driven after wake");
    a_dis_pin: assert property (@(posedge clk_link) disable iff (rst)
        $rose(monitorOutOutputDisable) |-> ##[1:300] !portAOe && !fastDetectBitsAOe)
        else $error("disable pin left data driven");
    a_core_pd: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(powerDownRequest) |-> ##[1:6] !corePowered && !referencePowered)
        else $error("power-down pin left core powered");
    a_ref_floats: assert property (@(posedge clk_link) disable iff (rst)
        $fell(referencePowered) |-> ##[0:300] !portAOe && !portBOe && !dataCaptureClockOe)
        else $error("full power-down left outputs driven");
    a_dco_pulse: assert property (@(posedge clk_link) disable iff (rst)
        $rose(dataCaptureClock) |=> dataCaptureClock ##1 !dataCaptureClock)
        else $error("capture clock pulse width wrong");
    a_a_at_rise: assert property (@(posedge clk_link) disable iff (rst)
        $rose(dataCaptureClock) |-> $stable(portAData) && $stable(portBData))
        else $error("data moved at capture clock rise");
    a_b_at_fall: assert property (@(posedge clk_link) disable iff (rst)
        $fell(dataCaptureClock) |-> $stable(portAData))
        else $error("data moved at capture clock fall");
    c_word: cover property (@(posedge clk_link) disable iff (rst) $rose(dataCaptureClock));
    c_pd: cover property (@(posedge clk_link) disable iff (rst) $fell(referencePowered));
    c_dis: cover property (@(posedge clk_link) disable iff (rst) $fell(fastDetectBitsAOe));
endmodule : aosd_output_stage_props

bind aosd_output_stage aosd_output_stage_props u_props (.clk_sys, .clk_link, .rst,
    .powerDownRequest, .monitorOutOutputDisable, .serialMode, .referencePowered, .corePowered,
    .portAData, .portBData, .portAOe, .portBOe, .fastDetectBitsAOe, .dataCaptureClock,
    .dataCaptureClockOe);

// File: dv/aosd_link_rx.sv
`timescale 1ns/10ps

module aosd_link_rx (
    // link pins
    input wire logic dataCaptureClock,
    input wire logic [13:0] portAData,
    input wire logic fastDetectBitsA,
    // captured words
    output logic [13:0] capA,
    output logic [13:0] capB,
    output logic capOvr,
    output int nWords = 0
);
    always @(posedge dataCaptureClock)
    begin
        capA <= portAData;
        capOvr <= fastDetectBitsA;
        nWords <= nWords + 1;
    end
    always @(negedge dataCaptureClock)
        capB <= portAData;
endmodule : aosd_link_rx

// File: dv/aosd_output_stage_tb.sv
`timescale 1ns/10ps

module aosd_output_stage_tb;
    logic clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, regWrite = 1'b0, serialMode = 1'b0;
    logic powerDownRequest = 1'b0, serialClockFormatSelect = 1'b0, monitorOutOutputDisable = 1'b0;
    logic signed [15:0] sampleA = 16'sh0000, sampleB = 16'sh0000;
    logic [8:0] regAddr = 9'h000;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic referencePowered, corePowered, portAOe, portBOe, dataCaptureClock, dataCaptureClockOe;
    logic fastDetectBitsA, fastDetectBitsAOe, fastDetectBitsB, fastDetectBitsBOe, capOvr;
    logic [13:0] portAData, portBData, capA, capB;
    int nWords, n_mismatch = 0, comparisons = 0;

    initial forever #50 clk_sys = ~clk_sys;
    initial
    begin
        #1.3;
        forever #3 clk_link = ~clk_link;
    end

    aosd_output_stage u_dut (.*);
    aosd_link_rx u_rx (.*);

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : tick
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        tick(1);
        regWrite = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] exp, input string what);
        regAddr = a;
        tick(1);
        chk(what, {8'h00, exp}, {8'h00, regRdata});
    endtask : rd
    // a dozen words flush the pipeline
    task automatic settle;
        int n0;
        n0 = nWords;
        for (int k = 0; k < 3000 && nWords < n0 + 12; k++) @(posedge clk_link);
        tick(1);
    endtask : settle

    task automatic t_regs;
        logic [7:0] t [6] = '{8'h00, 8'h00, 8'h01, 8'h07, 8'h01, 8'h01};
        logic [7:0] e [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h03};
        logic [7:0] st [6] = '{8'h07, 8'h0B, 8'h0F, 8'h0F, 8'h13, 8'h17};
        rd(aosd_pkg::REG_OUT_MODE, 8'h00, "om reset");
        wr(9'h1FF, 8'hFF);
        rd(9'h1FF, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++) wr(aosd_pkg::REG_FREQ0 + 9'(i), 8'h3C + 8'(i));
        for (int i = 0; i < 4; i++) rd(aosd_pkg::REG_FREQ0 + 9'(i), 8'h3C + 8'(i), "freq");
        for (int i = 0; i < 6; i++)
        begin
            wr(aosd_pkg::REG_TUNER_CTRL, t[i]);
            wr(aosd_pkg::REG_STAGE_EN, e[i]);
            rd(aosd_pkg::REG_STATUS, st[i], "mode");
        end
        wr(aosd_pkg::REG_TUNER_CTRL, 8'h00);
        wr(aosd_pkg::REG_STAGE_EN, 8'h00);
    endtask : t_regs

    task automatic t_codes;
        logic signed [15:0] s [5] = '{16'sh0000, 16'shC000, 16'sh3FFE, 16'sh4000, 16'shBFFE};
        logic [13:0] c [5] = '{14'h2000, 14'h0000, 14'h3FFF, 14'h3FFF, 14'h0000};
        logic [4:0] o = 5'h18;
        for (int f = 0; f < 2; f++)
            for (int i = 0; i < 5; i++)
            begin
                serialClockFormatSelect = f[0];
                sampleA = s[i];
                sampleB = s[i];
                settle();
                chk("code", {2'b00, c[i] ^ (f[0] ? 14'h2000 : 14'h0000)}, {2'b00, capA});
                chk("overrange", {15'h0000, o[i]}, {15'h0000, capOvr});
            end
    endtask : t_codes

    task automatic t_disable;
        monitorOutOutputDisable = 1'b1;
        tick(8);
        chk("pin off", 16'h0000, {13'h0000, portAOe, portBOe, fastDetectBitsAOe});
        monitorOutOutputDisable = 1'b0;
        tick(8);
        chk("pin on", 16'h0007, {13'h0000, portAOe, portBOe, fastDetectBitsAOe});
        serialMode = 1'b1;
        wr(aosd_pkg::REG_CHAN_SEL, 8'h01);
        wr(aosd_pkg::REG_OUT_MODE, 8'h10);
        tick(8);
        chk("bit off", 16'h0005, {12'h000, portAOe, portBOe, fastDetectBitsAOe, fastDetectBitsBOe});
        wr(aosd_pkg::REG_OUT_MODE, 8'h00);
        wr(aosd_pkg::REG_CHAN_SEL, 8'h03);
    endtask : t_disable

    task automatic t_power;
        serialMode = 1'b0;
        powerDownRequest = 1'b1;
        tick(8);
        chk("pin down", 16'h0000, {12'h000, portAOe, portBOe, dataCaptureClockOe, referencePowered});
        powerDownRequest = 1'b0;
        tick(8);
        chk("pin up", 16'h000F, {12'h000, portAOe, portBOe, dataCaptureClockOe, referencePowered});
        serialMode = 1'b1;
        wr(aosd_pkg::REG_POWER, 8'h02);
        tick(8);
        chk("standby", 16'h0002, {14'h0000, referencePowered, corePowered});
        wr(aosd_pkg::REG_POWER, 8'h01);
        tick(8);
        chk("reg down", 16'h0000, {13'h0000, referencePowered, corePowered, portAOe});
        wr(aosd_pkg::REG_POWER, 8'h00);
        tick(8);
    endtask : t_power

    task automatic t_serial;
        wr(aosd_pkg::REG_OUT_MODE, 8'h02);
        sampleA = 16'sh0000;
        settle();
        chk("gray", 16'h3000, {2'b00, capA});
        for (int h = 0; h < 2; h++)
        begin
            wr(aosd_pkg::REG_OUT_MODE, 8'h01);
            wr(aosd_pkg::REG_HB_CTRL, h[0] ? 8'h02 : 8'h00);
            sampleA = 16'sh2000;
            settle();
            chk("half-band", h[0] ? 16'h0000 : 16'h1000, {2'b00, capA});
        end
        wr(aosd_pkg::REG_HB_CTRL, 8'h00);
        wr(aosd_pkg::REG_OUT_MODE, 8'h21);
        sampleA = 16'sh0002;
        sampleB = 16'shFFFE;
        settle();
        chk("rise word", 16'h0001, {2'b00, capA});
        chk("fall word", 16'h3FFF, {2'b00, capB});
        chk("port b off", 16'h0000, {15'h0000, portBOe});
    endtask : t_serial

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    initial
    begin
        tick(10);
        rst = 1'b0;
        tick(2);
        t_regs();
        t_codes();
        t_disable();
        t_power();
        t_serial();
        give_verdict();
    end
    initial
    begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule : aosd_output_stage_tb
